// file: design/power_mode_wake_control.sv
// Power-mode controller: mode selection, clock gating and wake delay.
// Assumes one 100 MHz clock, a plain register port and synchronous wake inputs.
//
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module power_mode_wake_control (
    // Clock and reset
    input  wire logic                             clk_sys,
    input  wire logic                             nrst,
    // Register port
    input  wire logic [3:0]                       reg_addr,
    input  wire logic [7:0]                       reg_wdata,
    input  wire logic                             reg_wr,
    input  wire logic                             reg_rd,
    output logic      [7:0]                       reg_rdata_q,
    // CPU requests and wake sources
    input  wire logic                             sleep_req,
    input  wire logic                             irq_pending,
    input  wire logic                             irq_enabled,
    input  wire logic                             emu_active,
    input  wire logic                             flash_busy,
    // Clock controls
    output pwr_mode_pkg::clk_ctl_t                clk_ctl_q,
    output logic      [1:0]                       per_div_sel_q,
    output logic                                  int_osc_sel_q,
    output logic                                  low_power_q,
    output pwr_mode_pkg::mode_t                   mode_q
);
    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0] sys1_q;
    logic [7:0] sys2_q;
    logic [7:0] modstby_q;
    pwr_mode_pkg::mode_bits_t bits;
    pwr_mode_pkg::mode_t      mode_d;
    pwr_mode_pkg::mode_t      wake_target_q;
    logic                     wake_start;
    logic                     stab_done;
    logic                     wait_done;
    logic                     wake_ok;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            sys1_q    <= pwr_mode_pkg::SYS1_RESET;
            sys2_q    <= pwr_mode_pkg::SYS2_RESET;
            modstby_q <= pwr_mode_pkg::MODSTBY_RESET;
        end else if (reg_wr) begin
            unique case (reg_addr)
                pwr_mode_pkg::ADDR_SYSCTL1: sys1_q    <= reg_wdata;
                pwr_mode_pkg::ADDR_SYSCTL2: sys2_q    <= reg_wdata;
                pwr_mode_pkg::ADDR_MODSTBY: modstby_q <= reg_wdata;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            reg_rdata_q <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                pwr_mode_pkg::ADDR_SYSCTL1: reg_rdata_q <= sys1_q;
                pwr_mode_pkg::ADDR_SYSCTL2: reg_rdata_q <= sys2_q;
                pwr_mode_pkg::ADDR_MODSTBY: reg_rdata_q <= modstby_q;
                pwr_mode_pkg::ADDR_STATUS:  reg_rdata_q <= {4'h0, mode_q};
                default:                    reg_rdata_q <= 8'h00;
            endcase
        end else begin
            reg_rdata_q <= 8'h00;
        end
    end

    always_comb begin
        bits.low_speed_on = sys1_q[pwr_mode_pkg::SYS1_LOW_SPEED_ON_BIT];
        bits.software_standby = sys1_q[pwr_mode_pkg::SYS1_SOFTWARE_STANDBY_BIT];
        bits.timekeeper_mode_bit3 = sys1_q[pwr_mode_pkg::SYS1_TIMEKEEPER_MODE_BIT3_BIT];
        bits.medium_speed_on = sys2_q[pwr_mode_pkg::SYS2_MEDIUM_SPEED_ON_BIT];
        bits.direct_transfer_on = sys2_q[pwr_mode_pkg::SYS2_DIRECT_TRANSFER_ON_BIT];
    end

    // ------------------------------------------------------------------
    // Mode sequencer
    // ------------------------------------------------------------------
    assign wake_ok = irq_pending && irq_enabled;

    always_comb begin
        mode_d     = mode_q;
        wake_start = 1'b0;
        unique case (mode_q)
            pwr_mode_pkg::M_ACTIVE_HS, pwr_mode_pkg::M_ACTIVE_MS: begin
                if (sleep_req) begin
                    // Table of eight combinations.
                    if (!bits.direct_transfer_on) begin
                        if (!bits.software_standby && !bits.low_speed_on) begin
                            mode_d = bits.medium_speed_on ? pwr_mode_pkg::M_SLEEP_MS
                                               : pwr_mode_pkg::M_SLEEP_HS;
                        end else if (!bits.software_standby && bits.timekeeper_mode_bit3) begin
                            mode_d = pwr_mode_pkg::M_SUBSLEEP;
                        end else if (bits.software_standby && bits.timekeeper_mode_bit3) begin
                            mode_d = pwr_mode_pkg::M_WATCH;
                        end else if (bits.software_standby && !bits.low_speed_on) begin
                            mode_d = pwr_mode_pkg::M_STANDBY;
                        end
                    end else begin
                        if (!bits.software_standby && !bits.low_speed_on) begin
                            mode_d = bits.medium_speed_on ? pwr_mode_pkg::M_ACTIVE_MS
                                               : pwr_mode_pkg::M_ACTIVE_HS;
                        end else if (bits.software_standby && bits.timekeeper_mode_bit3 && bits.low_speed_on) begin
                            mode_d = pwr_mode_pkg::M_SUBACTIVE;
                        end
                    end
                end
            end
            pwr_mode_pkg::M_SLEEP_HS, pwr_mode_pkg::M_SLEEP_MS: begin
                if (wake_ok) begin
                    mode_d = bits.medium_speed_on ? pwr_mode_pkg::M_ACTIVE_MS
                                       : pwr_mode_pkg::M_ACTIVE_HS;
                end
            end
            pwr_mode_pkg::M_SUBSLEEP: begin
                if (wake_ok) begin
                    mode_d = pwr_mode_pkg::M_SUBACTIVE;
                end
            end
            pwr_mode_pkg::M_SUBACTIVE: begin
                if (sleep_req && bits.direct_transfer_on && bits.software_standby && bits.timekeeper_mode_bit3 && !bits.low_speed_on) begin
                    mode_d     = pwr_mode_pkg::M_WAKE_STAB;
                    wake_start = 1'b1;
                end else if (sleep_req && !bits.software_standby) begin
                    mode_d = pwr_mode_pkg::M_SUBSLEEP;
                end else if (sleep_req && bits.software_standby) begin
                    mode_d = pwr_mode_pkg::M_WATCH;
                end
            end
            pwr_mode_pkg::M_WATCH, pwr_mode_pkg::M_STANDBY: begin
                if (wake_ok) begin
                    mode_d     = pwr_mode_pkg::M_WAKE_STAB;
                    wake_start = 1'b1;
                end
            end
            pwr_mode_pkg::M_WAKE_STAB: begin
                if (stab_done) begin
                    mode_d = pwr_mode_pkg::M_WAKE_WAIT;
                end
            end
            pwr_mode_pkg::M_WAKE_WAIT: begin
                if (wait_done) begin
                    mode_d = wake_target_q;
                end
            end
            default: mode_d = pwr_mode_pkg::M_ACTIVE_HS;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mode_q <= pwr_mode_pkg::M_ACTIVE_HS;
        end else begin
            mode_q <= mode_d;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wake_target_q <= pwr_mode_pkg::M_ACTIVE_HS;
        end else if (wake_start) begin
            wake_target_q <= bits.medium_speed_on ? pwr_mode_pkg::M_ACTIVE_MS
                                       : pwr_mode_pkg::M_ACTIVE_HS;
        end
    end

    wake_wait_timer u_wait (
        .clk_sys          (clk_sys),
        .nrst             (nrst),
        .start            (wake_start),
        .wake_wait_select (sys1_q[pwr_mode_pkg::SYS1_STS_MSB:pwr_mode_pkg::SYS1_STS_LSB]),
        .stab_done_q      (stab_done),
        .wait_done_q      (wait_done)
    );

    // ------------------------------------------------------------------
    // Clock gating
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            clk_ctl_q <= '{1'b1, 1'b1, 1'b0, 1'b1, pwr_mode_pkg::PER_ALL};
        end else begin
            unique case (mode_d)
                pwr_mode_pkg::M_ACTIVE_HS, pwr_mode_pkg::M_ACTIVE_MS:
                    clk_ctl_q <= '{1'b1, 1'b1, 1'b0, 1'b1, ~modstby_q};
                pwr_mode_pkg::M_SLEEP_HS, pwr_mode_pkg::M_SLEEP_MS:
                    clk_ctl_q <= '{1'b1, 1'b1, 1'b0, 1'b0, ~modstby_q};
                pwr_mode_pkg::M_SUBACTIVE:
                    clk_ctl_q <= '{1'b0, 1'b0, 1'b1, 1'b1, ~modstby_q};
                pwr_mode_pkg::M_SUBSLEEP:
                    clk_ctl_q <= '{1'b0, 1'b0, 1'b1, 1'b0,
                                   pwr_mode_pkg::PER_SUBSLEEP & ~modstby_q};
                pwr_mode_pkg::M_WATCH:
                    clk_ctl_q <= '{1'b0, 1'b0, 1'b1, 1'b0,
                                   pwr_mode_pkg::PER_WATCH & ~modstby_q};
                pwr_mode_pkg::M_STANDBY:
                    clk_ctl_q <= '{1'b0, 1'b0, 1'b0, 1'b0, pwr_mode_pkg::PER_NONE};
                pwr_mode_pkg::M_WAKE_STAB, pwr_mode_pkg::M_WAKE_WAIT:
                    clk_ctl_q <= '{1'b1, 1'b1, 1'b0, 1'b0, pwr_mode_pkg::PER_NONE};
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            per_div_sel_q <= 2'h0;
            low_power_q   <= 1'b0;
            int_osc_sel_q <= 1'b0;
        end else begin
            per_div_sel_q <= sys2_q[pwr_mode_pkg::SYS2_DIV_MSB:pwr_mode_pkg::SYS2_DIV_LSB];
            low_power_q   <= (mode_d != pwr_mode_pkg::M_ACTIVE_HS);
            int_osc_sel_q <= emu_active && !flash_busy;
        end
    end

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    a_osc_off_standby: assert property (@(posedge clk_sys) disable iff (!nrst)
        (mode_q == pwr_mode_pkg::M_STANDBY) |-> !clk_ctl_q.sys_osc_en)
        else $error("System oscillator running in standby.");

    a_wake_restart: assert property (@(posedge clk_sys) disable iff (!nrst)
        (mode_q == pwr_mode_pkg::M_WATCH && wake_ok) |=> clk_ctl_q.sys_osc_en)
        else $error("Oscillator not restarted on wake.");

    a_cpu_held_wake: assert property (@(posedge clk_sys) disable iff (!nrst)
        (mode_q == pwr_mode_pkg::M_WAKE_WAIT && !wait_done) |-> !clk_ctl_q.cpu_clk_en)
        else $error("CPU released before wait ended.");

    a_wait_min: assert property (@(posedge clk_sys) disable iff (!nrst)
        $rose(stab_done) |-> !wait_done [*8])
        else $error("Wake wait shorter than eight states.");

    a_no_wake_masked: assert property (@(posedge clk_sys) disable iff (!nrst)
        (mode_q == pwr_mode_pkg::M_STANDBY && !irq_enabled) |=>
        (mode_q == pwr_mode_pkg::M_STANDBY))
        else $error("Masked request left standby.");

    a_standby_all_off: assert property (@(posedge clk_sys) disable iff (!nrst)
        (mode_q == pwr_mode_pkg::M_STANDBY) |-> (clk_ctl_q.per_clk_en == pwr_mode_pkg::PER_NONE))
        else $error("Peripheral clock on in standby.");

    a_sleep_cpu_off: assert property (@(posedge clk_sys) disable iff (!nrst)
        (mode_q == pwr_mode_pkg::M_SLEEP_HS) |-> (!clk_ctl_q.cpu_clk_en && clk_ctl_q.sys_clk_sel))
        else $error("High-speed sleep clocking wrong.");

    a_sub_active: assert property (@(posedge clk_sys) disable iff (!nrst)
        (mode_q == pwr_mode_pkg::M_SUBACTIVE) |-> (clk_ctl_q.cpu_clk_en && clk_ctl_q.sub_clk_sel))
        else $error("Subactive not on subclock.");

    a_low_power: assert property (@(posedge clk_sys) disable iff (!nrst)
        (mode_q == pwr_mode_pkg::M_ACTIVE_HS) |-> !low_power_q)
        else $error("High-speed active flagged low power.");

    a_emu_clock: assert property (@(posedge clk_sys) disable iff (!nrst)
        (emu_active && flash_busy) |=> !int_osc_sel_q)
        else $error("Internal oscillator used during flash work.");

endmodule
`default_nettype wire

// file: design/wake_wait_timer.sv
// Wake delay counter: stabilisation interval then selected wait.
// Assumes a start pulse from the mode controller on the same clock.
`timescale 1ns/1ps
`default_nettype none
module wake_wait_timer #(
    parameter int STAB_CYCLES = pwr_mode_pkg::OSC_STAB_CYCLES
) (
    // Clock and reset
    input  wire logic                           clk_sys,
    input  wire logic                           nrst,
    // Control
    input  wire logic                           start,
    input  wire logic [2:0]                     wake_wait_select,
    // Status
    output logic                                stab_done_q,
    output logic                                wait_done_q
);
    logic [pwr_mode_pkg::STAB_W-1:0] stab_cnt_q;
    logic [pwr_mode_pkg::WAIT_W-1:0] wait_cnt_q;
    logic [pwr_mode_pkg::WAIT_W-1:0] wait_len;
    logic                            run_q;

    // Selects 8 states up to 131072 states.
    always_comb begin
        unique case (wake_wait_select)
            3'h0: wait_len = 18'h0_2000;
            3'h1: wait_len = 18'h0_4000;
            3'h2: wait_len = 18'h1_0000;
            3'h3: wait_len = 18'h2_0000;
            3'h4: wait_len = 18'h0_0010;
            3'h5: wait_len = 18'h0_0400;
            3'h6: wait_len = 18'h0_0080;
            3'h7: wait_len = pwr_mode_pkg::WAIT_MIN;
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            run_q       <= 1'b0;
            stab_cnt_q  <= '0;
            wait_cnt_q  <= '0;
            stab_done_q <= 1'b0;
            wait_done_q <= 1'b0;
        end else if (start) begin
            run_q       <= 1'b1;
            stab_cnt_q  <= '0;
            wait_cnt_q  <= '0;
            stab_done_q <= 1'b0;
            wait_done_q <= 1'b0;
        end else if (run_q && !stab_done_q) begin
            stab_cnt_q <= stab_cnt_q + 1'b1;
            if (stab_cnt_q == pwr_mode_pkg::STAB_W'(STAB_CYCLES - 1)) begin
                stab_done_q <= 1'b1;
            end
        end else if (run_q && !wait_done_q) begin
            // Counts restarted clock states only after stabilisation.
            wait_cnt_q <= wait_cnt_q + 1'b1;
            if (wait_cnt_q == wait_len - 1'b1) begin
                wait_done_q <= 1'b1;
                run_q       <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// file: shared/pwr_mode_pkg.sv
// Constants, modes and carriers for the power-mode and wake controller.
// Assumes a single 100 MHz system clock domain and a plain strobed register port.
package pwr_mode_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [3:0] ADDR_SYSCTL1  = 4'h0;
    localparam logic [3:0] ADDR_SYSCTL2  = 4'h1;
    localparam logic [3:0] ADDR_MODSTBY  = 4'h2;
    localparam logic [3:0] ADDR_STATUS   = 4'h3;

    // system_control_one fields
    localparam int SYS1_SOFTWARE_STANDBY_BIT   = 7;
    localparam int SYS1_STS_LSB    = 4;
    localparam int SYS1_STS_MSB    = 6;
    localparam int SYS1_LOW_SPEED_ON_BIT   = 3;
    localparam int SYS1_TIMEKEEPER_MODE_BIT3_BIT   = 2;
    // system_control_two fields
    localparam int SYS2_MEDIUM_SPEED_ON_BIT   = 0;
    localparam int SYS2_DIRECT_TRANSFER_ON_BIT   = 1;
    localparam int SYS2_DIV_LSB    = 2;
    localparam int SYS2_DIV_MSB    = 3;

    localparam logic [7:0]  SYS1_RESET     = 8'h70;
    localparam logic [7:0]  SYS2_RESET     = 8'h00;
    localparam logic [7:0]  MODSTBY_RESET  = 8'h00;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int OSC_STAB_NS      = 10000;
    localparam int CLK_PERIOD_NS    = 10;
    localparam int OSC_STAB_CYCLES  = (OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int WAIT_W           = 18;
    localparam int STAB_W           = 20;
    localparam logic [WAIT_W-1:0] WAIT_MIN = 18'h0_0008;

    // ------------------------------------------------------------------
    // Modes
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        M_ACTIVE_HS, M_ACTIVE_MS, M_SUBACTIVE, M_SLEEP_HS, M_SLEEP_MS,
        M_SUBSLEEP, M_WATCH, M_STANDBY, M_WAKE_STAB, M_WAKE_WAIT
    } mode_t;

    // Peripheral clock enables: time base, timer C, timer F, timer G, serial,
    // event counter, display, A/D.
    localparam int NPERIPH = 8;
    localparam logic [7:0] PER_ALL      = 8'hFF;
    localparam logic [7:0] PER_SUBSLEEP = 8'h7F;
    localparam logic [7:0] PER_WATCH    = 8'h6D;
    localparam logic [7:0] PER_NONE     = 8'h00;

    typedef struct packed {
        logic       sys_osc_en;
        logic       sys_clk_sel;
        logic       sub_clk_sel;
        logic       cpu_clk_en;
        logic [7:0] per_clk_en;
    } clk_ctl_t;

    typedef struct packed {
        logic       low_speed_on;
        logic       medium_speed_on;
        logic       software_standby;
        logic       timekeeper_mode_bit3;
        logic       direct_transfer_on;
    } mode_bits_t;

endpackage

// file: verif/power_mode_wake_control_tb.sv
// Self-checking bench for the power-mode and wake controller.
// Assumes the design package is compiled first; the bench drives every port itself.
`timescale 1ns/1ps
`default_nettype none
module power_mode_wake_control_tb;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic                   clk_sys = 1'b0;
    logic                   nrst = 1'b0;
    logic [3:0]             reg_addr = 4'h0;
    logic [7:0]             reg_wdata = 8'h00;
    logic                   reg_wr = 1'b0;
    logic                   reg_rd = 1'b0;
    logic [7:0]             reg_rdata_q;
    logic                   sleep_req = 1'b0;
    logic                   irq_pending = 1'b0;
    logic                   irq_enabled = 1'b0;
    logic                   emu_active = 1'b0;
    logic                   flash_busy = 1'b0;
    pwr_mode_pkg::clk_ctl_t clk_ctl_q;
    logic [1:0]             per_div_sel_q;
    logic                   int_osc_sel_q;
    logic                   low_power_q;
    pwr_mode_pkg::mode_t    mode_q;
    int                     errors = 0;
    int                     num_checks = 0;

    always #5 clk_sys = ~clk_sys;

    power_mode_wake_control power_mode_wake_control_inst (
        .clk_sys(clk_sys), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .sleep_req(sleep_req),
        .irq_pending(irq_pending), .irq_enabled(irq_enabled), .emu_active(emu_active),
        .flash_busy(flash_busy), .clk_ctl_q(clk_ctl_q), .per_div_sel_q(per_div_sel_q),
        .int_osc_sel_q(int_osc_sel_q), .low_power_q(low_power_q), .mode_q(mode_q)
    );

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [17:0] exp, input logic [17:0] got);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    // Strobes are raised and dropped by non-blocking assignment at a rising edge.
    // One idle edge separates calls, so no strobe is assigned twice in one step.
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(what, 18'(exp), 18'(reg_rdata_q));
    endtask

    task automatic wait_mode(input pwr_mode_pkg::mode_t m);
        int i;
        for (i = 0; i < 200 && mode_q !== m; i++) begin
            @(posedge clk_sys);
            #1;
        end
        chk("mode", 18'(m), 18'(mode_q));
        if (mode_q !== m) wrap_up();
    endtask

    // Enter a mode by a one-cycle sleep request, so that a mode which also
    // decodes the request is not left again at once.
    task automatic enter(input logic [7:0] s1, input logic [7:0] s2,
                         input pwr_mode_pkg::mode_t m);
        wr(pwr_mode_pkg::ADDR_SYSCTL1, s1);
        wr(pwr_mode_pkg::ADDR_SYSCTL2, s2);
        @(posedge clk_sys);
        sleep_req <= 1'b1;
        @(posedge clk_sys);
        sleep_req <= 1'b0;
        wait_mode(m);
        chk("low_power", 18'h0_0001, 18'(low_power_q));
    endtask

    // Wake from a halted-oscillator mode; counts cycles until the CPU clock is back.
    task automatic wake_slow(input int states);
        int n;
        @(posedge clk_sys);
        irq_pending <= 1'b1;
        irq_enabled <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk("stab_mode", 18'(pwr_mode_pkg::M_WAKE_STAB), 18'(mode_q));
        chk("osc_restart", 18'h0_0001, 18'(clk_ctl_q.sys_osc_en));
        n = 1;
        while (clk_ctl_q.cpu_clk_en !== 1'b1 && n < 20000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        chk("wake_not_early", 18'h0_0001,
            18'(n >= pwr_mode_pkg::OSC_STAB_CYCLES + states));
        chk("wake_not_late", 18'h0_0001,
            18'(n <= pwr_mode_pkg::OSC_STAB_CYCLES + states + 4));
        if (n >= 20000) wrap_up();
        chk("mode_active", 18'(pwr_mode_pkg::M_ACTIVE_HS), 18'(mode_q));
        chk("active_full", 18'h0_0000, 18'(low_power_q));
        @(posedge clk_sys);
        irq_pending <= 1'b0;
        irq_enabled <= 1'b0;
        #1;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset_regs();
        chk("rst_mode", 18'(pwr_mode_pkg::M_ACTIVE_HS), 18'(mode_q));
        chk("rst_clk", 18'(12'hFFF), 18'({clk_ctl_q.sys_osc_en, clk_ctl_q.cpu_clk_en,
            clk_ctl_q.per_clk_en, 2'b11}));
        rd(pwr_mode_pkg::ADDR_SYSCTL1, pwr_mode_pkg::SYS1_RESET, "sys1_rst");
        rd(pwr_mode_pkg::ADDR_SYSCTL2, pwr_mode_pkg::SYS2_RESET, "sys2_rst");
        rd(pwr_mode_pkg::ADDR_STATUS, 8'h00, "status_rst");
        wr(4'hF, 8'hA5);
        rd(4'hF, 8'h00, "unmapped");
        wr(pwr_mode_pkg::ADDR_SYSCTL1, 8'h5C);
        rd(pwr_mode_pkg::ADDR_SYSCTL1, 8'h5C, "sys1_rw");
    endtask

    task automatic t_osc_sel();
        @(posedge clk_sys);
        emu_active <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("int_osc_run", 18'h0_0001, 18'(int_osc_sel_q));
        @(posedge clk_sys);
        flash_busy <= 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        chk("int_osc_flash", 18'h0_0000, 18'(int_osc_sel_q));
        @(posedge clk_sys);
        emu_active <= 1'b0;
        flash_busy <= 1'b0;
        #1;
    endtask

    task automatic t_module_standby();
        wr(pwr_mode_pkg::ADDR_MODSTBY, 8'h81);
        repeat (2) @(posedge clk_sys);
        #1;
        chk("per_masked", 18'h0_007E, 18'(clk_ctl_q.per_clk_en));
        chk("cpu_kept", 18'h0_0001, 18'(clk_ctl_q.cpu_clk_en));
        rd(pwr_mode_pkg::ADDR_MODSTBY, 8'h81, "modstby_rw");
        wr(pwr_mode_pkg::ADDR_MODSTBY, 8'h00);
    endtask

    task automatic t_standby();
        enter(8'hF0, 8'h00, pwr_mode_pkg::M_STANDBY);
        chk("stby_osc", 18'h0_0000, 18'(clk_ctl_q.sys_osc_en));
        chk("stby_cpu", 18'h0_0000, 18'(clk_ctl_q.cpu_clk_en));
        chk("stby_per", 18'(pwr_mode_pkg::PER_NONE), 18'(clk_ctl_q.per_clk_en));
        // A pending request that is not enabled must leave the mode alone.
        @(posedge clk_sys);
        irq_pending <= 1'b1;
        repeat (20) @(posedge clk_sys);
        #1;
        chk("no_wake", 18'(pwr_mode_pkg::M_STANDBY), 18'(mode_q));
        wake_slow(8);
    endtask

    task automatic t_watch();
        enter(8'hC4, 8'h00, pwr_mode_pkg::M_WATCH);
        chk("watch_osc", 18'h0_0000, 18'(clk_ctl_q.sys_osc_en));
        chk("watch_cpu", 18'h0_0000, 18'(clk_ctl_q.cpu_clk_en));
        chk("watch_per", 18'(pwr_mode_pkg::PER_WATCH), 18'(clk_ctl_q.per_clk_en));
        chk("watch_sub", 18'h0_0001, 18'(clk_ctl_q.sub_clk_sel));
        wake_slow(16);
    endtask

    task automatic t_sleep();
        enter(8'h70, 8'h00, pwr_mode_pkg::M_SLEEP_HS);
        chk("hs_cpu", 18'h0_0000, 18'(clk_ctl_q.cpu_clk_en));
        chk("hs_per", 18'(pwr_mode_pkg::PER_ALL), 18'(clk_ctl_q.per_clk_en));
        chk("hs_osc", 18'h0_0001, 18'(clk_ctl_q.sys_osc_en));
        @(posedge clk_sys);
        irq_pending <= 1'b1;
        irq_enabled <= 1'b1;
        wait_mode(pwr_mode_pkg::M_ACTIVE_HS);
        @(posedge clk_sys);
        irq_pending <= 1'b0;
        irq_enabled <= 1'b0;
        #1;
        enter(8'h70, 8'h09, pwr_mode_pkg::M_SLEEP_MS);
        chk("ms_cpu", 18'h0_0000, 18'(clk_ctl_q.cpu_clk_en));
        chk("ms_div", 18'h0_0002, 18'(per_div_sel_q));
        chk("ms_per", 18'(pwr_mode_pkg::PER_ALL), 18'(clk_ctl_q.per_clk_en));
    endtask

    // Subclock modes, then the direct transfer back with the shortest wait.
    task automatic t_subactive();
        enter(8'hFC, 8'h02, pwr_mode_pkg::M_SUBACTIVE);
        chk("sub_cpu", 18'h0_0001, 18'(clk_ctl_q.cpu_clk_en));
        chk("sub_clk", 18'h0_0001, 18'(clk_ctl_q.sub_clk_sel));
        chk("sub_osc", 18'h0_0000, 18'(clk_ctl_q.sys_osc_en));
        enter(8'h7C, 8'h02, pwr_mode_pkg::M_SUBSLEEP);
        chk("ssl_cpu", 18'h0_0000, 18'(clk_ctl_q.cpu_clk_en));
        chk("ssl_per", 18'(pwr_mode_pkg::PER_SUBSLEEP), 18'(clk_ctl_q.per_clk_en));
        @(posedge clk_sys);
        irq_pending <= 1'b1;
        irq_enabled <= 1'b1;
        wait_mode(pwr_mode_pkg::M_SUBACTIVE);
        @(posedge clk_sys);
        irq_pending <= 1'b0;
        irq_enabled <= 1'b0;
        enter(8'hF4, 8'h02, pwr_mode_pkg::M_WAKE_STAB);
        repeat (pwr_mode_pkg::OSC_STAB_CYCLES + 7) @(posedge clk_sys);
        #1;
        chk("sub_wake_held", 18'h0_0000, 18'(clk_ctl_q.cpu_clk_en));
        @(posedge clk_sys);
        #1;
        chk("sub_wake_mode", 18'(pwr_mode_pkg::M_ACTIVE_HS), 18'(mode_q));
    endtask

    // Software picks a long wait, as advised for a weak crystal.
    task automatic t_long_wait();
        enter(8'h80, 8'h00, pwr_mode_pkg::M_STANDBY);
        wake_slow(8192);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (5) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        #1;
        t_reset_regs();
        t_osc_sel();
        t_module_standby();
        t_standby();
        t_watch();
        t_subactive();
        t_long_wait();
        t_sleep();
        wrap_up();
    end
endmodule
`default_nettype wire
